// file: tdt_consts.svh
`ifndef TDT_CONSTS_SVH
`define TDT_CONSTS_SVH

// -----------------------------------------------------------------
// configuration port geometry
// -----------------------------------------------------------------
`define TDT_ADDR_W 12
`define TDT_DATA_W 8

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define TDT_OFS_TRIM_B 12'h07f
`define TDT_OFS_TRIM_C 12'h080
`define TDT_OFS_TRIM_D 12'h081
`define TDT_OFS_DITHER 12'h09d
`define TDT_OFS_LSB_CTRL 12'h160

// -----------------------------------------------------------------
// reset values (before the fuse preload lands)
// -----------------------------------------------------------------
`define TDT_RST_TRIM 8'h00
`define TDT_RST_DITHER 8'h00
`define TDT_RST_LSB_CTRL 8'h00
`define TDT_RDATA_NONE 8'h00

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define TDT_DITH_EN_BIT 0
`define TDT_DITH_AMP_BIT 1
`define TDT_DITH_ERR_BIT 2
`define TDT_MARK_EN_BIT 0

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define TDT_SYNC_STAGES 2
`define TDT_SAMPLE_LATENCY 8
`define TDT_CONV_RES 12
`define TDT_LINK_N 16
`define TDT_NUM_TRIM 3

`endif

// file: tdt_pkg.sv
package tdt_pkg;

    typedef logic [7:0] tdt_byte_t;

    typedef enum logic [1:0] {
        TDT_FUSE_REQ,
        TDT_FUSE_WAIT,
        TDT_RUN
    } tdt_fuse_state_t;

endpackage

// file: tdt_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tdt_ctl_if;
    logic marker_insert_enable;
    logic ila_active;

    modport source (
        output marker_insert_enable,
        output ila_active
    );

    modport sink (
        input marker_insert_enable,
        input ila_active
    );
endinterface

`default_nettype wire

// file: tdt_marker_insert.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdt_consts.svh"

module tdt_marker_insert
    import tdt_pkg::*;
#(
    parameter int RES = `TDT_CONV_RES,
    parameter int N = `TDT_LINK_N,
    parameter int SAMPLE_LATENCY = `TDT_SAMPLE_LATENCY
) (
    input wire logic mclk,
    input wire logic rst,
    tdt_ctl_if.sink ctl,
    input wire logic [RES-1:0] conv_sample,
    input wire logic marker_pin,
    output logic [N-1:0] link_sample_q,
    output logic ila_cs_q
);
    localparam int PAD = N - RES;
    localparam int LINE = SAMPLE_LATENCY - `TDT_SYNC_STAGES;

    // -----------------------------------------------------------------
    // pin synchroniser, first stage feeds only the second
    // -----------------------------------------------------------------
    logic sync1_q;
    logic sync2_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= marker_pin;
            sync2_q <= sync1_q;
        end
    end

    // -----------------------------------------------------------------
    // delay line: sync + line equals the analog sample latency
    // -----------------------------------------------------------------
    logic [LINE:0] line_q;
    assign line_q[0] = sync2_q;
    for (genvar i = 1; i <= LINE; i++) begin : g_line
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                line_q[i] <= 1'b0;
            end else begin
                line_q[i] <= line_q[i-1];
            end
        end
    end

    // -----------------------------------------------------------------
    // sample assembly
    // -----------------------------------------------------------------
    logic [N-1:0] sample_d;
    logic cs_d;
    logic insert;
    always_comb begin
        insert = ctl.marker_insert_enable & ~ctl.ila_active;
        // converter bits sit above the pad, so a wider field keeps all data bits
        sample_d = N'(conv_sample) << PAD;
        if (insert) begin
            sample_d[0] = line_q[LINE];
        end
        cs_d = 1'b0;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link_sample_q <= '0;
            ila_cs_q <= 1'b0;
        end else begin
            link_sample_q <= sample_d;
            ila_cs_q <= cs_d;
        end
    end
endmodule // tdt_marker_insert

`default_nettype wire

// file: tdt_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdt_consts.svh"


module tdt_regs
    import tdt_pkg::*;
#(
    parameter int RES = `TDT_CONV_RES,
    parameter int N = `TDT_LINK_N,
    parameter int SAMPLE_LATENCY = `TDT_SAMPLE_LATENCY
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [`TDT_ADDR_W-1:0] cfg_addr,
    input wire logic [`TDT_DATA_W-1:0] cfg_wdata,
    output logic [`TDT_DATA_W-1:0] cfg_rdata_q,
    output logic cfg_rvalid_q,
    output logic fuse_req_q,
    input wire logic fuse_valid,
    input wire logic [7:0] fuse_trim_b,
    input wire logic [7:0] fuse_trim_c,
    input wire logic [7:0] fuse_trim_d,
    input wire logic [7:0] fuse_dither,
    output logic [7:0] term_trim_b_q,
    output logic [7:0] term_trim_c_q,
    output logic [7:0] term_trim_d_q,
    output logic dither_enable_q,
    output logic dither_amplitude_select_q,
    output logic rounding_error_steer_q,
    output logic marker_insert_enable_q,
    output logic preload_done_q,
    input wire logic [RES-1:0] conv_sample,
    input wire logic marker_pin,
    input wire logic ila_active,
    output logic [N-1:0] link_sample_q,
    output logic ila_cs_q
);

    // -----------------------------------------------------------------
    // fuse preload sequencer
    // -----------------------------------------------------------------
    // async reset can only load constants, so fuse contents are fetched
    // by a clocked sequence after release
    tdt_fuse_state_t fuse_st_q;
    tdt_fuse_state_t fuse_st_d;
    logic fuse_req_d;
    logic preload_done_d;
    logic fuse_load;

    always_comb begin
        fuse_st_d = fuse_st_q;
        fuse_req_d = 1'b0;
        preload_done_d = preload_done_q;
        fuse_load = 1'b0;
        unique case (fuse_st_q)
            TDT_FUSE_REQ: begin
                fuse_req_d = 1'b1;
                fuse_st_d = TDT_FUSE_WAIT;
            end
            TDT_FUSE_WAIT: begin
                if (fuse_valid) begin
                    fuse_load = 1'b1;
                    preload_done_d = 1'b1;
                    fuse_st_d = TDT_RUN;
                end
            end
            TDT_RUN: begin
                fuse_st_d = TDT_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fuse_st_q <= TDT_FUSE_REQ;
            fuse_req_q <= 1'b0;
            preload_done_q <= 1'b0;
        end else begin
            fuse_st_q <= fuse_st_d;
            fuse_req_q <= fuse_req_d;
            preload_done_q <= preload_done_d;
        end
    end

    // -----------------------------------------------------------------
    // termination trims, one per channel B..D
    // -----------------------------------------------------------------
    localparam logic [`TDT_ADDR_W-1:0] TRIM_OFS [`TDT_NUM_TRIM] = '{
        `TDT_OFS_TRIM_B, `TDT_OFS_TRIM_C, `TDT_OFS_TRIM_D
    };

    logic [7:0] fuse_trim [`TDT_NUM_TRIM];
    tdt_byte_t trim_q [`TDT_NUM_TRIM];
    tdt_byte_t trim_d [`TDT_NUM_TRIM];
    logic [`TDT_NUM_TRIM-1:0] trim_hit;

    assign fuse_trim[0] = fuse_trim_b;
    assign fuse_trim[1] = fuse_trim_c;
    assign fuse_trim[2] = fuse_trim_d;

    for (genvar ch = 0; ch < `TDT_NUM_TRIM; ch++) begin : g_trim
        always_comb begin
            trim_hit[ch] = (cfg_addr == TRIM_OFS[ch]);
            trim_d[ch] = trim_q[ch];
            // a software write in the load cycle wins: it is the newer value
            if (fuse_load) begin
                trim_d[ch] = fuse_trim[ch];
            end
            if (cfg_wr_en && trim_hit[ch]) begin
                trim_d[ch] = cfg_wdata;
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                trim_q[ch] <= `TDT_RST_TRIM;
            end else begin
                trim_q[ch] <= trim_d[ch];
            end
        end
    end

    assign term_trim_b_q = trim_q[0];
    assign term_trim_c_q = trim_q[1];
    assign term_trim_d_q = trim_q[2];

    // -----------------------------------------------------------------
    // dither control and sample lsb control
    // -----------------------------------------------------------------
    // reserved bits are stored and read back as written; only the low
    // fields steer hardware
    tdt_byte_t dither_q;
    tdt_byte_t dither_d;
    tdt_byte_t lsb_ctrl_q;
    tdt_byte_t lsb_ctrl_d;

    always_comb begin
        dither_d = dither_q;
        lsb_ctrl_d = lsb_ctrl_q;
        if (fuse_load) begin
            dither_d = fuse_dither;
        end
        if (cfg_wr_en && cfg_addr == `TDT_OFS_DITHER) begin
            dither_d = cfg_wdata;
        end
        if (cfg_wr_en && cfg_addr == `TDT_OFS_LSB_CTRL) begin
            lsb_ctrl_d = cfg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dither_q <= `TDT_RST_DITHER;
            lsb_ctrl_q <= `TDT_RST_LSB_CTRL;
        end else begin
            dither_q <= dither_d;
            lsb_ctrl_q <= lsb_ctrl_d;
        end
    end

    assign dither_enable_q = dither_q[`TDT_DITH_EN_BIT];
    assign dither_amplitude_select_q = dither_q[`TDT_DITH_AMP_BIT];
    assign rounding_error_steer_q = dither_q[`TDT_DITH_ERR_BIT];
    assign marker_insert_enable_q = lsb_ctrl_q[`TDT_MARK_EN_BIT];

    // -----------------------------------------------------------------
    // read path, one cycle after the strobe
    // -----------------------------------------------------------------
    tdt_byte_t rdata_d;
    logic rvalid_d;

    always_comb begin
        rdata_d = `TDT_RDATA_NONE;
        rvalid_d = cfg_rd_en;
        if (cfg_rd_en) begin
            for (int ch = 0; ch < `TDT_NUM_TRIM; ch++) begin
                if (trim_hit[ch]) begin
                    rdata_d = trim_q[ch];
                end
            end
            if (cfg_addr == `TDT_OFS_DITHER) begin
                rdata_d = dither_q;
            end
            if (cfg_addr == `TDT_OFS_LSB_CTRL) begin
                rdata_d = lsb_ctrl_q;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_rdata_q <= `TDT_RDATA_NONE;
            cfg_rvalid_q <= 1'b0;
        end else begin
            cfg_rdata_q <= rdata_d;
            cfg_rvalid_q <= rvalid_d;
        end
    end

    // -----------------------------------------------------------------
    // marker insertion into link samples
    // -----------------------------------------------------------------
    // the receiver input enable lives elsewhere; software pairs it with
    // the insertion enable
    tdt_ctl_if ctl_if ();
    assign ctl_if.marker_insert_enable = lsb_ctrl_q[`TDT_MARK_EN_BIT];
    assign ctl_if.ila_active = ila_active;

    tdt_marker_insert #(
        .RES(RES),
        .N(N),
        .SAMPLE_LATENCY(SAMPLE_LATENCY)
    ) u_insert (
        .mclk(mclk),
        .rst(rst),
        .ctl(ctl_if.sink),
        .conv_sample(conv_sample),
        .marker_pin(marker_pin),
        .link_sample_q(link_sample_q),
        .ila_cs_q(ila_cs_q)
    );

endmodule // tdt_regs

`default_nettype wire

// file: tdt_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdt_consts.svh"

module tdt_regs_props
    import tdt_pkg::*;
#(
    parameter int RES = 12,
    parameter int N = 16,
    parameter int SAMPLE_LATENCY = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [`TDT_ADDR_W-1:0] cfg_addr,
    input wire logic [`TDT_DATA_W-1:0] cfg_wdata,
    input wire logic [`TDT_DATA_W-1:0] cfg_rdata_q,
    input wire logic cfg_rvalid_q,
    input wire logic preload_done_q,
    input wire logic [7:0] fuse_trim_b,
    input wire logic [7:0] fuse_dither,
    input wire logic [7:0] term_trim_b_q,
    input wire logic [7:0] term_trim_c_q,
    input wire logic dither_enable_q,
    input wire logic dither_amplitude_select_q,
    input wire logic rounding_error_steer_q,
    input wire logic marker_insert_enable_q,
    input wire logic [RES-1:0] conv_sample,
    input wire logic marker_pin,
    input wire logic ila_active,
    input wire logic [N-1:0] link_sample_q,
    input wire logic ila_cs_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // edges since reset release; the marker line is flushed by reset
    logic [3:0] age_q;
    logic [3:0] age_d;
    always_comb age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) age_q <= 4'h0;
        else age_q <= age_d;
    end

    chk_read_answer: assert property (cfg_rd_en |=> cfg_rvalid_q)
        else $error("read strobe not answered");
    chk_read_idle: assert property (!cfg_rd_en |=> !cfg_rvalid_q && cfg_rdata_q == 8'h00)
        else $error("read data outside a read");
    chk_read_trim_b: assert property (cfg_rd_en && cfg_addr == `TDT_OFS_TRIM_B
        |=> cfg_rdata_q == $past(term_trim_b_q)) else $error("input b trim read wrong");
    chk_trim_c_write: assert property (cfg_wr_en && cfg_addr == `TDT_OFS_TRIM_C
        |=> term_trim_c_q == $past(cfg_wdata)) else $error("input c trim write lost");
    chk_dither_write: assert property (cfg_wr_en && cfg_addr == `TDT_OFS_DITHER
        |=> {rounding_error_steer_q, dither_amplitude_select_q, dither_enable_q}
        == $past(cfg_wdata[2:0])) else $error("dither bits wrong");
    chk_fuse_preload: assert property ($rose(preload_done_q) && !$past(cfg_wr_en)
        |-> term_trim_b_q == $past(fuse_trim_b) && dither_enable_q == $past(fuse_dither[0]))
        else $error("fuse preload wrong");
    chk_sample_data: assert property (age_q != 4'h0
        |-> link_sample_q[N-1 -: RES] == $past(conv_sample)) else $error("sample data wrong");
    chk_marker_lsb: assert property (age_q > 4'(SAMPLE_LATENCY + 1)
        |-> link_sample_q[0] == ($past(marker_pin, SAMPLE_LATENCY + 1)
        && $past(marker_insert_enable_q) && !$past(ila_active))) else $error("marker bit wrong");
    chk_ila_no_cs: assert property (ila_cs_q == 1'b0)
        else $error("control bits reported in alignment");
endmodule // tdt_regs_props

`default_nettype wire

// file: tb_trim_dither_timestamp_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdt_consts.svh"

module tb_trim_dither_timestamp_regs
    import tdt_pkg::*;
;
    localparam int SL = 8;
    logic mclk, rst, cfg_wr_en, cfg_rd_en, fuse_valid, marker_pin, ila_active;
    logic [11:0] cfg_addr, conv_sample;
    logic [7:0] cfg_wdata, cfg_rdata_q, d;
    logic [7:0] fz [4];
    logic [7:0] shadow [6];
    logic [11:0] addrs [6];
    logic cfg_rvalid_q, fuse_req_q, preload_done_q, ila_cs_q;
    logic [7:0] tb_q, tc_q, td_q;
    logic den_q, damp_q, derr_q, men_q;
    logic [15:0] link_sample_q;
    int seed, num_errors, samples_checked, i, k;

    tdt_regs #(.RES(12), .N(16), .SAMPLE_LATENCY(SL)) dut_u (.mclk(mclk), .rst(rst),
        .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
        .fuse_req_q(fuse_req_q), .fuse_valid(fuse_valid), .fuse_trim_b(fz[0]),
        .fuse_trim_c(fz[1]), .fuse_trim_d(fz[2]), .fuse_dither(fz[3]),
        .term_trim_b_q(tb_q), .term_trim_c_q(tc_q), .term_trim_d_q(td_q),
        .dither_enable_q(den_q), .dither_amplitude_select_q(damp_q),
        .rounding_error_steer_q(derr_q), .marker_insert_enable_q(men_q),
        .preload_done_q(preload_done_q), .conv_sample(conv_sample), .marker_pin(marker_pin),
        .ila_active(ila_active), .link_sample_q(link_sample_q), .ila_cs_q(ila_cs_q));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [27:0] exp_out();
        return {shadow[0], shadow[1], shadow[2], shadow[3][2:0], shadow[4][0]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        cfg_wr_en = 1'b1;
        cfg_addr = a;
        cfg_wdata = v;
        @(negedge mclk);
        cfg_wr_en = 1'b0;
        @(negedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        cfg_rd_en = 1'b1;
        cfg_addr = a;
        @(negedge mclk);
        cfg_rd_en = 1'b0;
        v = cfg_rdata_q;
        check("rvalid", cfg_rvalid_q, 1);
        @(negedge mclk);
        check("rvalid pulse", cfg_rvalid_q, 0);
    endtask

    task automatic complete_run;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(negedge mclk) conv_sample <= rst ? 12'h000 : conv_sample + 12'h5a7;

    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        complete_run();
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        seed = 29;
        rst = 1'b1;
        cfg_wr_en = 1'b0;
        cfg_rd_en = 1'b0;
        cfg_addr = 12'h000;
        cfg_wdata = 8'h00;
        fuse_valid = 1'b0;
        marker_pin = 1'b0;
        ila_active = 1'b0;
        addrs = '{`TDT_OFS_TRIM_B, `TDT_OFS_TRIM_C, `TDT_OFS_TRIM_D, `TDT_OFS_DITHER,
            `TDT_OFS_LSB_CTRL, 12'h082};
        for (i = 0; i < 4; i++) fz[i] = 8'($random(seed));
        for (i = 0; i < 6; i++) shadow[i] = 8'h00;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        check("fuse_req", fuse_req_q, 1);
        rd(addrs[1], d);
        check("early read", d, 0);
        check("fuse_req pulse", fuse_req_q, 0);
        fuse_valid = 1'b1;
        @(negedge mclk);
        fuse_valid = 1'b0;
        for (i = 0; i < 4; i++) shadow[i] = fz[i];
        check("preload_done", preload_done_q, 1);
        check("preload", {tb_q, tc_q, td_q, derr_q, damp_q, den_q, men_q}, exp_out());
        for (i = 0; i < 8; i++) begin
            wr(addrs[3], i[7:0]);
            shadow[3] = i[7:0];
            check("dither", {derr_q, damp_q, den_q}, i[2:0]);
        end
        // software keeps reserved fields at zero
        for (i = 0; i < 40; i++) begin
            k = $unsigned($random(seed)) % 6;
            d = 8'($random(seed));
            if (k == 3) d = d & 8'h07;
            if (k == 4) d = d & 8'h01;
            wr(addrs[k], d);
            if (k < 5) shadow[k] = d;
            check("outputs", {tb_q, tc_q, td_q, derr_q, damp_q, den_q, men_q}, exp_out());
            rd(addrs[k], d);
            check("readback", d, shadow[k]);
        end
        // receiver input enable lives outside this block, nothing to pair here
        for (i = 0; i < 4; i++) begin
            wr(addrs[4], {7'h00, i[0]});
            ila_active = i[1];
            marker_pin = 1'b1;
            @(negedge mclk);
            marker_pin = 1'b0;
            repeat (SL) @(negedge mclk);
            check("link", link_sample_q, {conv_sample, 3'b000, i[0] & ~i[1]});
            check("ila cs", ila_cs_q, 0);
            ila_active = 1'b0;
        end
        // mid-run reset: one fresh load, a write in the load cycle wins
        rst = 1'b1;
        @(negedge mclk);
        check("reset outputs", {tb_q, tc_q, td_q, den_q, men_q, preload_done_q}, 0);
        for (i = 0; i < 4; i++) fz[i] = 8'($random(seed));
        rst = 1'b0;
        @(negedge mclk);
        check("fuse_req again", fuse_req_q, 1);
        fuse_valid = 1'b1;
        d = 8'($random(seed));
        wr(addrs[1], d);
        for (i = 0; i < 4; i++) shadow[i] = (i == 1) ? d : fz[i];
        shadow[4] = 8'h00;
        // a second valid after the take must be ignored
        for (i = 0; i < 4; i++) fz[i] = ~fz[i];
        @(negedge mclk);
        fuse_valid = 1'b0;
        check("reload", {tb_q, tc_q, td_q, derr_q, damp_q, den_q, men_q}, exp_out());
        check("preload_done held", preload_done_q, 1);
        complete_run();
    end
endmodule // tb_trim_dither_timestamp_regs

bind tdt_regs tdt_regs_props #(.RES(RES), .N(N), .SAMPLE_LATENCY(SAMPLE_LATENCY)) chk_u (
    .mclk(mclk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q), .preload_done_q(preload_done_q), .fuse_trim_b(fuse_trim_b),
    .fuse_dither(fuse_dither), .term_trim_b_q(term_trim_b_q), .term_trim_c_q(term_trim_c_q),
    .dither_enable_q(dither_enable_q), .dither_amplitude_select_q(dither_amplitude_select_q),
    .rounding_error_steer_q(rounding_error_steer_q),
    .marker_insert_enable_q(marker_insert_enable_q), .conv_sample(conv_sample),
    .marker_pin(marker_pin), .ila_active(ila_active), .link_sample_q(link_sample_q),
    .ila_cs_q(ila_cs_q));

`default_nettype wire
